// file: pkg/rtc_pkg.sv
// Notes on behaviour
// R01: Clock access opens only after 64 key bits match, one per write on lane 0.
// R02: Before the key is recognised every cycle goes to the memory array.
// R03: After recognition, 64 cycles move time data; the memory array is untouched.
// R04: Unlock begins with a read to any address; it resets the key pointer to 0.
// R05: Each unlock write compares lane 0 with the key bit; a match advances.
// R06: A mismatch freezes the pointer and later writes are ignored for matching.
// R07: A read during recognition abandons the sequence and restarts the pointer.
// R08: Key is C5 3A A3 5C C5 3A A3 5C, each byte least significant bit first.
// R09: Each transfer cycle moves one lane 0 bit; output enable reads, write enable writes.
// R10: Transfer walks bit 0 of register 0 through bit 7 of register 7.
// R11: All time registers hold binary coded decimal values.
// R12: Hours bit 7 set selects 12-hour counting, clear selects 24-hour counting.
// R13: Hours bit 5 is the afternoon flag in 12-hour mode, tens-of-hours bit in 24-hour.
// R14: Day bit 4 set ignores the abort pin; clear lets a low pin abort the transfer.
// R15: Day bit 5 set stops the oscillator; clear lets time advance.
// R16: Abort-ignore and oscillator-stop bits are both 1 after reset.
// R17: Unused bits of registers 1 to 6 read 0; writes to them have no effect.
// R18: Cycles with chip enable inactive do not disturb a sequence in progress.
// R19: Host updates each register as a whole group of 8 bits.
// R20: Host should reserve one memory address as scratch for unlock writes.
// R21: Calendar ends short months correctly, with leap years.
// R22: After the 64th transfer cycle the block returns to memory mode.
// R23: Registers are hundredths, seconds, minutes, hours, weekday, date, month, year.
package rtc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 8;
  localparam int MEM_WORDS = 32768;
  localparam int FIFO_DEPTH = 16;
  localparam int SERIAL_LANE = 0;
  localparam logic [5:0] BIT_LAST = 6'h3f;
  localparam logic [63:0] UNLOCK_KEY = 64'h5ca3_3ac5_5ca3_3ac5;
  localparam int HOUR_12H_BIT = 7;
  localparam int HOUR_PM_BIT = 5;
  localparam int DAY_NOABORT_BIT = 4;
  localparam int DAY_OSCOFF_BIT = 5;
  localparam logic [2:0] REG_HUND = 3'h0;
  localparam logic [2:0] REG_SEC = 3'h1;
  localparam logic [2:0] REG_MIN = 3'h2;
  localparam logic [2:0] REG_HOUR = 3'h3;
  localparam logic [2:0] REG_WDAY = 3'h4;
  localparam logic [2:0] REG_DATE = 3'h5;
  localparam logic [2:0] REG_MONTH = 3'h6;
  localparam logic [2:0] REG_YEAR = 3'h7;
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'hff, 8'h7f, 8'h7f, 8'hbf, 8'h37, 8'h3f, 8'h1f, 8'hff};
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] BCD_H11 = 8'h11;
  localparam logic [7:0] BCD_H12 = 8'h12;
  localparam logic [7:0] BCD_H23 = 8'h23;
  localparam logic [7:0] BCD_WDAY_MAX = 8'h07;
  localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_US = 10000;
  localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pin_bus_t;

  typedef struct packed {
    logic [2:0] index;
    logic [7:0] value;
  } time_wr_t;

  typedef enum logic [1:0] {st_idle, st_match, st_reject, st_xfer} unlock_state_t;
endpackage

// file: src/time_wr_fifo.sv
`timescale 1ns/1ps
module time_wr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // time_wr_fifo

// file: src/hidden_rtc_serial_unlock.sv
`timescale 1ns/1ps
module hidden_rtc_serial_unlock
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Memory strobes
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  // Address, top bit shared with the abort input
  input wire logic [ADDR_W-2:0] addr_low,
  input wire logic shared_address_abort_pin,
  // Data pins, lane 0 is the serial data lane
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Status
  output logic clock_access
);
  pin_bus_t pins_raw;
  pin_bus_t sync1_reg;
  pin_bus_t sync2_reg;
  pin_bus_t sync3_reg;
  pin_bus_t filt_reg;
  logic wr_act;
  logic rd_act;
  logic wr_act_reg;
  logic rd_act_reg;
  logic wr_end;
  logic rd_end;
  logic [ADDR_W-1:0] cyc_addr_reg;
  logic [DATA_W-1:0] cyc_data_reg;
  unlock_state_t state_reg;
  logic [5:0] bit_ptr_reg;
  logic [7:0] mem [MEM_WORDS];
  logic [7:0] time_reg [NUM_REGS];
  logic [7:0] time_next [NUM_REGS];
  logic [63:0] snap_reg;
  logic [7:0] asm_reg;
  time_wr_t push_reg;
  logic push_valid_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  time_wr_t fifo_out;
  logic abort;
  logic xfer_done;
  logic [16:0] tick_cnt_reg;
  logic tick;
  logic c_sec;
  logic c_min;
  logic c_hour;
  logic c_day;
  logic c_date;
  logic c_month;
  logic c_unused;
  logic [7:0] hour_bcd;
  logic [7:0] mdays;
  logic [8:0] inc_res;

  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    logic [8:0] r;
    r = {1'b0, v};
    if (v >= hi) begin
      r = {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] month, input logic [7:0] year);
    logic leap;
    logic [7:0] d;
    leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                   : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
    case (month)
      8'h02: d = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
      default: d = 8'h31;
    endcase
    return d;
  endfunction

  assign pins_raw = '{ce_n: ce_n, oe_n: oe_n, we_n: we_n,
                      addr: {shared_address_abort_pin, addr_low}, data: data_in};

  // Three stages; a change is taken only when stages two and three agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      sync2_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      sync3_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      filt_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) filt_reg <= sync3_reg;
    end
  end

  // Only chip-enabled strobes form cycles, so foreign cycles pass unseen
  assign wr_act = !filt_reg.ce_n && !filt_reg.we_n; // R18
  assign rd_act = !filt_reg.ce_n && !filt_reg.oe_n && filt_reg.we_n; // R18
  assign wr_end = wr_act_reg && !wr_act;
  assign rd_end = rd_act_reg && !rd_act;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_act_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      cyc_addr_reg <= '0;
      cyc_data_reg <= '0;
    end else begin
      wr_act_reg <= wr_act;
      rd_act_reg <= rd_act;
      if (wr_act || rd_act) begin
        cyc_addr_reg <= filt_reg.addr;
        cyc_data_reg <= filt_reg.data;
      end
    end
  end

  assign abort = (state_reg == st_xfer) && !time_reg[REG_WDAY][DAY_NOABORT_BIT] && !filt_reg.addr[ADDR_W-1]; // R14
  assign xfer_done = (state_reg == st_xfer) && (wr_end || rd_end) && (bit_ptr_reg == BIT_LAST);

  // Key recognition and transfer sequencing
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= st_idle;
      bit_ptr_reg <= '0;
    end else begin
      case (state_reg)
        st_idle, st_match, st_reject: begin
          if (rd_end) begin
            state_reg <= st_match; // R04 R07
            bit_ptr_reg <= '0;
          end else if (wr_end && state_reg == st_match) begin
            if (cyc_data_reg[SERIAL_LANE] == UNLOCK_KEY[bit_ptr_reg]) begin // R05 R08
              bit_ptr_reg <= bit_ptr_reg + 6'h01;
              if (bit_ptr_reg == BIT_LAST) begin
                state_reg <= st_xfer; // R01
              end
            end else begin
              state_reg <= st_reject; // R06
            end
          end
        end
        st_xfer: begin
          if (abort) begin
            state_reg <= st_idle; // R14
            bit_ptr_reg <= '0;
          end else if (xfer_done) begin
            state_reg <= st_idle; // R22
            bit_ptr_reg <= '0;
          end else if (rd_end || (wr_end && (!push_valid_reg || fifo_in_ready))) begin
            bit_ptr_reg <= bit_ptr_reg + 6'h01; // R09 R10
          end
        end
        default: begin
          state_reg <= st_idle;
          bit_ptr_reg <= '0;
        end
      endcase
    end
  end

  // Memory array sees every cycle outside the transfer
  always_ff @(posedge mclk) begin
    if (wr_end && state_reg != st_xfer) begin
      mem[cyc_addr_reg] <= cyc_data_reg; // R02 R03
    end
  end

  // Read data; in transfer only lane 0 carries the snapshot bit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_out <= '0;
      data_oe <= 1'b0;
      clock_access <= 1'b0;
    end else begin
      data_oe <= rd_act;
      clock_access <= (state_reg == st_xfer);
      if (state_reg == st_xfer) begin
        data_out <= {{(DATA_W-1){1'b0}}, snap_reg[bit_ptr_reg]}; // R03 R09
      end else begin
        data_out <= mem[filt_reg.addr]; // R02
      end
    end
  end

  // Snapshot at unlock so a read-out cannot tear across a tick
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      snap_reg <= '0;
    end else if (state_reg == st_match && wr_end && bit_ptr_reg == BIT_LAST) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        snap_reg[i*8 +: 8] <= time_reg[i]; // R10
      end
    end
  end

  // Written bits gather into whole bytes before they reach the fifo
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      asm_reg <= '0;
      push_reg <= '0;
      push_valid_reg <= 1'b0;
    end else begin
      if (push_valid_reg && fifo_in_ready) push_valid_reg <= 1'b0;
      if (state_reg == st_xfer && wr_end && !abort && (!push_valid_reg || fifo_in_ready)) begin
        asm_reg[bit_ptr_reg[2:0]] <= cyc_data_reg[SERIAL_LANE]; // R09
        if (bit_ptr_reg[2:0] == 3'h7) begin
          push_reg.index <= bit_ptr_reg[5:3]; // R19
          push_reg.value <= {cyc_data_reg[SERIAL_LANE], asm_reg[6:0]};
          push_valid_reg <= 1'b1;
        end
      end
      if (abort) push_valid_reg <= 1'b0;
    end
  end

  // Commits wait for the end of the transfer, so an abort can still discard them
  assign fifo_out_ready = (state_reg != st_xfer) && !tick;

  time_wr_fifo #(.WIDTH($bits(time_wr_t)), .DEPTH(FIFO_DEPTH)) time_wr_fifo_i (
    .clk(mclk),
    .nrst(nrst),
    .flush(abort),
    .in_valid(push_valid_reg && !abort),
    .in_ready(fifo_in_ready),
    .in_data(push_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // Hundredths tick from the system clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= '0;
    end else if (tick || time_reg[REG_WDAY][DAY_OSCOFF_BIT]) begin
      tick_cnt_reg <= '0; // R15
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 17'h00001;
    end
  end
  assign tick = (tick_cnt_reg == 17'(TICK_DIV - 1)) && !time_reg[REG_WDAY][DAY_OSCOFF_BIT]; // R15

  // BCD counting chain
  always_comb begin
    c_hour = 1'b0;
    hour_bcd = BCD_ZERO;
    c_unused = 1'b0;
    inc_res = 9'h000;
    for (int i = 0; i < NUM_REGS; i++) time_next[i] = time_reg[i];
    {c_sec, time_next[REG_HUND]} = bcd_inc(time_reg[REG_HUND], BCD_ZERO, BCD_99); // R11 R23
    {c_min, time_next[REG_SEC]} = bcd_inc(time_reg[REG_SEC], BCD_ZERO, BCD_59);
    if (!c_sec) time_next[REG_SEC] = time_reg[REG_SEC];
    c_min = c_min && c_sec;
    {c_unused, time_next[REG_MIN]} = bcd_inc(time_reg[REG_MIN], BCD_ZERO, BCD_59);
    if (!c_min) time_next[REG_MIN] = time_reg[REG_MIN];
    if (c_min && c_unused) begin
      if (time_reg[REG_HOUR][HOUR_12H_BIT]) begin // R12
        hour_bcd = {3'b000, time_reg[REG_HOUR][4:0]};
        if (hour_bcd == BCD_H11) begin
          time_next[REG_HOUR][4:0] = BCD_H12[4:0];
          time_next[REG_HOUR][HOUR_PM_BIT] = !time_reg[REG_HOUR][HOUR_PM_BIT]; // R13
          c_hour = time_reg[REG_HOUR][HOUR_PM_BIT];
        end else begin
          inc_res = bcd_inc(hour_bcd, BCD_ONE, BCD_H12);
          hour_bcd = inc_res[7:0];
          time_next[REG_HOUR][4:0] = hour_bcd[4:0];
        end
      end else begin
        {c_hour, hour_bcd} = bcd_inc({2'b00, time_reg[REG_HOUR][5:0]}, BCD_ZERO, BCD_H23); // R13
        time_next[REG_HOUR][5:0] = hour_bcd[5:0];
      end
    end
    c_day = c_hour;
    mdays = month_days(time_reg[REG_MONTH], time_reg[REG_YEAR]);
    {c_date, time_next[REG_DATE]} = bcd_inc(time_reg[REG_DATE], BCD_ONE, mdays); // R21
    {c_month, time_next[REG_MONTH]} = bcd_inc(time_reg[REG_MONTH], BCD_ONE, BCD_MONTH_MAX);
    if (c_day) begin
      inc_res = bcd_inc({5'b00000, time_reg[REG_WDAY][2:0]}, BCD_ONE, BCD_WDAY_MAX);
      time_next[REG_WDAY][2:0] = inc_res[2:0];
    end else begin
      time_next[REG_DATE] = time_reg[REG_DATE];
    end
    if (!(c_day && c_date)) time_next[REG_MONTH] = time_reg[REG_MONTH];
    if (c_day && c_date && c_month) begin
      inc_res = bcd_inc(time_reg[REG_YEAR], BCD_ZERO, BCD_99);
      time_next[REG_YEAR] = inc_res[7:0];
    end
  end

  // Time registers: tick and committed bytes never share a cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_REGS; i++) time_reg[i] <= REG_RESET[i]; // R16
    end else if (tick) begin
      for (int i = 0; i < NUM_REGS; i++) time_reg[i] <= time_next[i];
    end else if (fifo_out_valid && fifo_out_ready) begin
      time_reg[fifo_out.index] <= fifo_out.value & REG_MASK[fifo_out.index]; // R17
    end
  end
endmodule // hidden_rtc_serial_unlock

// file: tb/rtc_props.sv
`timescale 1ns/1ps
module rtc_props
  import rtc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Strobes and address
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [ADDR_W-2:0] addr_low,
  input wire logic shared_address_abort_pin,
  // Data and status
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic clock_access
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  wire logic rd_pins = !ce_n && !oe_n && we_n;

  // Pins pass a 3-flop sync, so a drive can never start sooner than that
  read_drive_a: assert property ($rose(data_oe) |-> $past(rd_pins, 3))
    else $error("output drive without a read strobe");
  write_nodrive_a: assert property ((!ce_n && !we_n) [*6] |-> !data_oe)
    else $error("output driven during a write cycle");
  read_answer_a: assert property (rd_pins [*8] |-> data_oe)
    else $error("read strobe left unanswered");
  lane_only_a: assert property (clock_access && data_oe && $past(data_oe, 2) |-> data_out[7:1] == 7'h00)
    else $error("transfer read drives more than lane 0");
  key_done_a: assert property ($rose(clock_access) |-> !data_oe)
    else $error("clock access opened by a read");
  deselect_quiet_a: assert property (ce_n [*8] |-> !data_oe)
    else $error("output driven while deselected");
  read_stable_a: assert property (data_oe && $past(data_oe, 2) |-> $stable(data_out))
    else $error("read data moved within one cycle");
  release_drop_a: assert property ($fell(data_oe) |-> !$past(rd_pins, 3))
    else $error("output dropped while read still active");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |-> !data_oe && !clock_access)
    else $error("outputs active during reset");

  cover property ($rose(clock_access));
  cover property ($fell(clock_access));
  cover property (clock_access && data_oe);
endmodule // rtc_props

bind hidden_rtc_serial_unlock rtc_props #(.TICK_DIV(TICK_DIV)) rtc_props_i (
  .mclk, .nrst, .ce_n, .oe_n, .we_n, .addr_low, .shared_address_abort_pin,
  .data_in, .data_out, .data_oe, .clock_access
);

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  // Clock and read data
  input wire logic mclk,
  input wire logic [7:0] rd_data,
  // Strobes, address and data toward the device
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [14:0] addr,
  output logic [7:0] data
);
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 15'h4000;
    data = 8'h00;
  end

  // Strobe and idle last 8 clocks each, above the 6 the pin filter needs
  task automatic cyc(input logic sel, rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk);
    addr = a;
    data = rd ? ~data : d;
    ce_n = ~sel;
    oe_n = ~rd;
    we_n = rd;
    repeat (8) @(negedge mclk);
    q = rd_data;
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    // Released bus shows the inverse, so stale data never looks valid
    data = ~data;
    repeat (8) @(negedge mclk);
  endtask

  task automatic park(input logic [14:0] a);
    @(negedge mclk);
    addr = a;
  endtask
endmodule // host_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import rtc_pkg::*;
  logic mclk;
  logic nrst;
  logic ce_n, oe_n, we_n;
  logic [14:0] haddr;
  logic [7:0] hdata;
  logic [7:0] data_out;
  logic data_oe;
  logic clock_access;
  logic [7:0] q;
  int error_cnt = 0;
  int total_checks = 0;

  host_model host_model_i (.mclk, .rd_data(data_out), .ce_n, .oe_n, .we_n, .addr(haddr), .data(hdata));

  hidden_rtc_serial_unlock #(.TICK_DIV(10)) hidden_rtc_serial_unlock_i (
    .mclk, .nrst, .ce_n, .oe_n, .we_n, .addr_low(haddr[13:0]), .shared_address_abort_pin(haddr[14]),
    .data_in(hdata), .data_out, .data_oe, .clock_access
  );

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Unlock writes all land on one scratch byte
  task automatic keybits(input int lo, input int hi, input logic noise);
    logic [7:0] d;
    for (int i = lo; i < hi; i++) begin
      host_model_i.cyc(1'b1, 1'b0, 15'h4005, {7'h7f, UNLOCK_KEY[i]}, d);
      if (noise) host_model_i.cyc(1'b0, 1'b0, 15'h4006, {8{~UNLOCK_KEY[i]}}, d);
    end
  endtask

  task automatic unlock(input logic noise);
    host_model_i.cyc(1'b1, 1'b1, 15'h4005, 8'h00, q);
    keybits(0, 64, noise);
  endtask

  task automatic xfer_wr(input logic [63:0] v, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) host_model_i.cyc(1'b1, 1'b0, 15'h4007, {7'h00, v[i]}, d);
  endtask

  task automatic xfer_rd(output logic [63:0] v);
    logic [7:0] d;
    for (int i = 0; i < 64; i++) begin
      host_model_i.cyc(1'b1, 1'b1, 15'h4007, 8'h00, d);
      v[i] = d[0];
    end
  endtask

  task automatic regs(input logic [63:0] v, input logic [63:0] e);
    for (int k = 0; k < 8; k++) chk($sformatf("reg%0d", k), v[8*k+:8], e[8*k+:8]);
  endtask

  task automatic abort_pulse;
    host_model_i.park(15'h0007);
    repeat (10) @(negedge mclk);
    host_model_i.park(15'h4007);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    test_done();
  end

  initial begin
    logic [63:0] v, w, m, r;
    for (int k = 0; k < 8; k++) begin
      m[8*k+:8] = REG_MASK[k];
      r[8*k+:8] = REG_RESET[k];
    end
    nrst = 1'b0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    host_model_i.cyc(1'b1, 1'b0, 15'h4007, 8'h3c, q);
    host_model_i.cyc(1'b1, 1'b1, 15'h4007, 8'h00, q);
    chk("mem", q, 8'h3c);
    unlock(1'b0);
    abort_pulse();
    chk("access", {7'h00, clock_access}, 8'h01);
    xfer_rd(v);
    regs(v, r);
    chk("access_end", {7'h00, clock_access}, 8'h00);
    $display("test reset_values done");
    // Stopped oscillator keeps the values fixed while reserved bits are probed
    w = 64'h99ff_ffe9_ffff_ff00;
    unlock(1'b0);
    xfer_wr(w, 64);
    host_model_i.cyc(1'b1, 1'b1, 15'h4007, 8'h00, q);
    chk("mem_kept", q, 8'h3c);
    unlock(1'b0);
    xfer_wr(~w, 16);
    abort_pulse();
    chk("access_abort", {7'h00, clock_access}, 8'h00);
    unlock(1'b0);
    xfer_rd(v);
    regs(v, w & m);
    $display("test mask_abort done");
    host_model_i.cyc(1'b1, 1'b1, 15'h4005, 8'h00, q);
    host_model_i.cyc(1'b1, 1'b0, 15'h4005, {7'h00, ~UNLOCK_KEY[0]}, q);
    keybits(0, 64, 1'b0);
    chk("access_bad", {7'h00, clock_access}, 8'h00);
    host_model_i.cyc(1'b1, 1'b1, 15'h4005, 8'h00, q);
    keybits(0, 40, 1'b0);
    host_model_i.cyc(1'b1, 1'b1, 15'h4005, 8'h00, q);
    keybits(40, 64, 1'b0);
    chk("access_restart", {7'h00, clock_access}, 8'h00);
    unlock(1'b1);
    chk("access_noise", {7'h00, clock_access}, 8'h01);
    xfer_rd(v);
    regs(v, w & m);
    $display("test key_sequences done");
    // One second of running crosses midnight at the end of February
    unlock(1'b0);
    xfer_wr(64'h2302_2811_2359_5999, 64);
    unlock(1'b0);
    xfer_rd(v);
    regs(v & 64'hffff_ffff_ffff_0000, 64'h2303_0112_0000_0000);
    chk("hund_bcd", {7'h00, v[3:0] < 4'ha && v[7:4] < 4'ha}, 8'h01);
    // Stop the clock first, so the byte commits of the next write cannot race a tick
    unlock(1'b0);
    xfer_wr(64'h0001_0131_0000_0000, 64);
    unlock(1'b0);
    xfer_wr(64'h2302_2811_b159_5999, 64);
    unlock(1'b0);
    xfer_rd(v);
    regs(v & 64'hffff_ffff_ffff_0000, 64'h2303_0112_9200_0000);
    $display("test clock_run done");
    test_done();
  end
endmodule // testbench
